// ==== core/cmd_loss_prot.sv ====
// command loss protection core with register port
//
// Notes on behaviour
// - keypad loss reacts only when the command source is keypad (0) or jog use is protected.
// - keypad action 0 passes the speed command through untouched.
// - keypad action 1 drives code-29 output terminals while lost.
// - keypad action 2, the default, blocks the output on loss.
// - keypad action 3 ramps to stop over the trip decel time.
// - with the multi key set to jog (0) jog use is also protected.
// - speed loss from analog, comm or keypad and comm run loss count.
// - command loss action 1, the default, blocks the output.
// - decelerate mode ramps to stop over the trip decel time.
// - hold input mode uses the 10 s average of the speed input.
// - hold output mode uses the 10 s average of the output freq.
// - preset mode runs at the preset clamped to start..max, reset 0.
// - loss is declared after the decision time, 0.0-120 s, reset 1.0; the code does not clamp it and takes up to 6553.5 s.
// - level 0 treats the analog input lost at half of x1 or below.
// - command loss action 5 selects the preset frequency.
// - command loss action 2 selects the decelerate reaction.
`timescale 1ns/100ps
module cmd_loss_prot #(
  parameter int unsigned TICK_CYCLES = cmdloss_pkg::TICK_CYCLES,
  parameter int unsigned AVG_DEPTH   = cmdloss_pkg::AVG_DEPTH
) (
  // clock and reset
  input  wire logic                          I_CORE_CLK,
  input  wire logic                          I_ARST_N,
  // register port
  input  wire logic [cmdloss_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [31:0]                   I_WDATA,
  input  wire logic                          I_WR,
  input  wire logic                          I_RD,
  output logic      [31:0]                   O_RDATA,
  // command sources
  input  wire logic [cmdloss_pkg::FREQ_W-1:0] I_SPEED_CMD,
  input  wire logic [cmdloss_pkg::AI_W-1:0]  I_ANALOG_IN,
  input  wire logic                          I_KEYPAD_OK,
  input  wire logic                          I_JOG_ACTIVE,
  input  wire logic                          I_COMM_SPD_LOST,
  input  wire logic                          I_COMM_RUN_LOST,
  // drive controls
  output logic      [cmdloss_pkg::FREQ_W-1:0] O_OPER_FREQ,
  output logic                               O_OUT_BLOCK,
  output logic                               O_DECEL_STOP,
  output logic      [cmdloss_pkg::TERM_N-1:0] O_TERM,
  output logic                               O_IRQ
);
  localparam int unsigned FW = cmdloss_pkg::FREQ_W;
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  function automatic logic term_drive(input logic [7:0] fn,
                                      input logic warn,
                                      input logic lost);
    term_drive = ((fn == cmdloss_pkg::FN_LOST_KPD) && warn) ||
                 ((fn == cmdloss_pkg::FN_LOST_CMD) && lost);
  endfunction

  function automatic logic [15:0] clamp_f(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp_f = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [6:0]  src_cfg_q;
  logic [1:0]  kpd_act_q;
  logic [2:0]  cmd_act_q;
  logic [15:0] dec_time_q;
  logic [15:0] decide_q;
  logic [15:0] preset_q;
  logic        ai_level_q;
  logic [11:0] ai_x1_q;
  logic [31:0] flimit_q;
  logic [23:0] term_fn_q;
  logic [cmdloss_pkg::IRQ_N-1:0] irq_en_q;
  logic [cmdloss_pkg::IRQ_N-1:0] irq_stat_q;

  logic [1:0]  cmd_src;
  logic [1:0]  spd_src;
  logic [2:0]  mkey;
  logic [15:0] f_start;
  logic [15:0] f_max;
  assign cmd_src = src_cfg_q[cmdloss_pkg::SRC_CMD_LSB +: 2];
  assign spd_src = src_cfg_q[cmdloss_pkg::SRC_SPD_LSB +: 2];
  assign mkey    = src_cfg_q[cmdloss_pkg::SRC_MKEY_LSB +: 3];
  assign f_start = flimit_q[15:0];
  assign f_max   = flimit_q[cmdloss_pkg::FL_MAX_LSB +: 16];

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      src_cfg_q  <= cmdloss_pkg::RST_SRC_CFG;
      kpd_act_q  <= cmdloss_pkg::RST_KPD_ACT;
      cmd_act_q  <= cmdloss_pkg::RST_CMD_ACT;
      dec_time_q <= cmdloss_pkg::RST_DEC_TIME;
      decide_q   <= cmdloss_pkg::RST_DECIDE;
      preset_q   <= cmdloss_pkg::RST_PRESET;
      ai_level_q <= cmdloss_pkg::RST_AI_LEVEL;
      ai_x1_q    <= cmdloss_pkg::RST_AI_X1;
      flimit_q   <= cmdloss_pkg::RST_FLIMIT;
      term_fn_q  <= cmdloss_pkg::RST_TERM_FN;
      irq_en_q   <= '0;
    end else if (I_WR) begin
      unique case (I_ADDR)
        cmdloss_pkg::OFS_SRC_CFG:  src_cfg_q  <= I_WDATA[6:0];
        cmdloss_pkg::OFS_KPD_ACT:  kpd_act_q  <= I_WDATA[1:0];
        cmdloss_pkg::OFS_CMD_ACT:  cmd_act_q  <= I_WDATA[2:0];
        cmdloss_pkg::OFS_DEC_TIME: dec_time_q <= I_WDATA[15:0];
        cmdloss_pkg::OFS_DECIDE:   decide_q   <= I_WDATA[15:0];
        cmdloss_pkg::OFS_PRESET:   preset_q   <= I_WDATA[15:0];
        cmdloss_pkg::OFS_AI_LEVEL: ai_level_q <= I_WDATA[0];
        cmdloss_pkg::OFS_AI_X1:    ai_x1_q    <= I_WDATA[11:0];
        cmdloss_pkg::OFS_FLIMIT:   flimit_q   <= I_WDATA;
        cmdloss_pkg::OFS_TERM_FN:  term_fn_q  <= I_WDATA[23:0];
        cmdloss_pkg::OFS_IRQ_EN:
          irq_en_q <= I_WDATA[cmdloss_pkg::IRQ_N-1:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // 100 ms tick
  // ---------------------------------------------------------------
  logic [TW-1:0] tick_cnt_q;
  logic          tick;
  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // loss detection
  // ---------------------------------------------------------------
  logic        kpd_apply;
  logic        kpd_lost_q;
  logic        ai_lost;
  logic        spd_raw;
  logic        loss_raw;
  logic        cmd_lost_q;
  logic [15:0] loss_cnt_q;

  assign kpd_apply = (cmd_src == cmdloss_pkg::SRC_KEYPAD) ||
                     ((mkey == cmdloss_pkg::MKEY_JOG) &&
                      I_JOG_ACTIVE);
  assign ai_lost = (ai_level_q == cmdloss_pkg::AI_HALF_X1) ?
                   (I_ANALOG_IN <= (ai_x1_q >> 1)) :
                   (I_ANALOG_IN < ai_x1_q);

  always_comb begin
    unique case (spd_src)
      cmdloss_pkg::SRC_ANALOG: spd_raw = ai_lost;
      cmdloss_pkg::SRC_COMM:   spd_raw = I_COMM_SPD_LOST;
      cmdloss_pkg::SRC_KEYPAD: spd_raw = !I_KEYPAD_OK;
      default:                 spd_raw = 1'b0;
    endcase
  end
  assign loss_raw = spd_raw || ((cmd_src == cmdloss_pkg::SRC_COMM) &&
                                I_COMM_RUN_LOST);

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      kpd_lost_q <= 1'b0;
    end else begin
      kpd_lost_q <= kpd_apply && !I_KEYPAD_OK;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      loss_cnt_q <= '0;
      cmd_lost_q <= 1'b0;
    end else if (!loss_raw) begin
      loss_cnt_q <= '0;
      cmd_lost_q <= 1'b0;
    end else begin
      if (tick && loss_cnt_q < decide_q) begin
        loss_cnt_q <= loss_cnt_q + 1'b1;
      end
      cmd_lost_q <= (loss_cnt_q >= decide_q);
    end
  end

  // ---------------------------------------------------------------
  // reaction select
  // ---------------------------------------------------------------
  logic block_d;
  logic dec_d;
  logic warn_d;
  assign block_d = (kpd_lost_q && kpd_act_q == cmdloss_pkg::KPD_FREE) ||
                   (cmd_lost_q && cmd_act_q == cmdloss_pkg::CL_FREE);
  assign dec_d = !block_d &&
                 ((kpd_lost_q && kpd_act_q == cmdloss_pkg::KPD_DEC) ||
                  (cmd_lost_q && cmd_act_q == cmdloss_pkg::CL_DEC));
  assign warn_d = kpd_lost_q && kpd_act_q == cmdloss_pkg::KPD_WARN;

  // ---------------------------------------------------------------
  // averagers
  // ---------------------------------------------------------------
  avg_if #(.W(FW)) avg_in ();
  avg_if #(.W(FW)) avg_out ();
  assign avg_in.tick    = tick;
  assign avg_in.freeze  = cmd_lost_q;
  assign avg_in.sample  = I_SPEED_CMD;
  assign avg_out.tick   = tick;
  assign avg_out.freeze = cmd_lost_q;
  assign avg_out.sample = O_OPER_FREQ;

  window_avg #(.W(FW), .DEPTH(AVG_DEPTH)) u_avg_in (
    .I_CORE_CLK (I_CORE_CLK),
    .I_ARST_N   (I_ARST_N),
    .a          (avg_in)
  );
  window_avg #(.W(FW), .DEPTH(AVG_DEPTH)) u_avg_out (
    .I_CORE_CLK (I_CORE_CLK),
    .I_ARST_N   (I_ARST_N),
    .a          (avg_out)
  );

  // ---------------------------------------------------------------
  // operating frequency and ramp
  // ---------------------------------------------------------------
  logic [31:0] acc_q;

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_OPER_FREQ <= '0;
      acc_q       <= '0;
    end else if (block_d) begin
      O_OPER_FREQ <= '0;
      acc_q       <= '0;
    end else if (dec_d) begin
      if (dec_time_q == '0) begin
        O_OPER_FREQ <= '0;
      end else if (acc_q >= 32'(dec_time_q)) begin
        O_OPER_FREQ <= (O_OPER_FREQ == '0) ? '0 : O_OPER_FREQ - 1'b1;
        acc_q       <= acc_q - 32'(dec_time_q);
      end else if (tick) begin
        acc_q <= acc_q + 32'(f_max);
      end
    end else begin
      acc_q <= '0;
      if (cmd_lost_q) begin
        unique case (cmd_act_q)
          cmdloss_pkg::CL_HOLD_IN:  O_OPER_FREQ <= avg_in.avg;
          cmdloss_pkg::CL_HOLD_OUT: O_OPER_FREQ <= avg_out.avg;
          cmdloss_pkg::CL_PRESET:
            O_OPER_FREQ <= clamp_f(preset_q, f_start, f_max);
          default:                  O_OPER_FREQ <= I_SPEED_CMD;
        endcase
      end else begin
        O_OPER_FREQ <= I_SPEED_CMD;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_OUT_BLOCK  <= 1'b0;
      O_DECEL_STOP <= 1'b0;
    end else begin
      O_OUT_BLOCK  <= block_d;
      O_DECEL_STOP <= dec_d;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_TERM <= '0;
    end else begin
      for (int i = 0; i < cmdloss_pkg::TERM_N; i++) begin
        O_TERM[i] <= term_drive(term_fn_q[8*i +: 8], warn_d,
                                cmd_lost_q);
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts and read port
  // ---------------------------------------------------------------
  logic                          kpd_lost_p_q;
  logic                          cmd_lost_p_q;
  logic [cmdloss_pkg::IRQ_N-1:0] ev;
  logic [cmdloss_pkg::IRQ_N-1:0] clr;
  assign ev  = {cmd_lost_p_q && !cmd_lost_q, cmd_lost_q && !cmd_lost_p_q,
                kpd_lost_q && !kpd_lost_p_q};
  assign clr = (I_WR && I_ADDR == cmdloss_pkg::OFS_IRQ_CLR) ?
               I_WDATA[cmdloss_pkg::IRQ_N-1:0] : '0;

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      kpd_lost_p_q <= 1'b0;
      cmd_lost_p_q <= 1'b0;
      irq_stat_q   <= '0;
      O_IRQ        <= 1'b0;
    end else begin
      kpd_lost_p_q <= kpd_lost_q;
      cmd_lost_p_q <= cmd_lost_q;
      irq_stat_q   <= (irq_stat_q & ~clr) | ev;
      O_IRQ        <= |(irq_stat_q & irq_en_q);
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= '0;
    end else if (!I_RD) begin
      O_RDATA <= '0;
    end else begin
      unique case (I_ADDR)
        cmdloss_pkg::OFS_SRC_CFG:  O_RDATA <= 32'(src_cfg_q);
        cmdloss_pkg::OFS_KPD_ACT:  O_RDATA <= 32'(kpd_act_q);
        cmdloss_pkg::OFS_CMD_ACT:  O_RDATA <= 32'(cmd_act_q);
        cmdloss_pkg::OFS_DEC_TIME: O_RDATA <= 32'(dec_time_q);
        cmdloss_pkg::OFS_DECIDE:   O_RDATA <= 32'(decide_q);
        cmdloss_pkg::OFS_PRESET:   O_RDATA <= 32'(preset_q);
        cmdloss_pkg::OFS_AI_LEVEL: O_RDATA <= 32'(ai_level_q);
        cmdloss_pkg::OFS_AI_X1:    O_RDATA <= 32'(ai_x1_q);
        cmdloss_pkg::OFS_FLIMIT:   O_RDATA <= flimit_q;
        cmdloss_pkg::OFS_TERM_FN:  O_RDATA <= 32'(term_fn_q);
        cmdloss_pkg::OFS_STATE:
          O_RDATA <= 32'({O_OUT_BLOCK, O_DECEL_STOP, cmd_lost_q,
                          kpd_lost_q});
        cmdloss_pkg::OFS_IRQ_STAT: O_RDATA <= 32'(irq_stat_q);
        cmdloss_pkg::OFS_IRQ_EN:   O_RDATA <= 32'(irq_en_q);
        cmdloss_pkg::OFS_FREQ:     O_RDATA <= 32'(O_OPER_FREQ);
        default:                   O_RDATA <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);

  kpd_source_a: assert property (
    (cmd_src != cmdloss_pkg::SRC_KEYPAD && !I_JOG_ACTIVE) |=> !kpd_lost_q)
    else $error("keypad loss outside keypad source");
  pass_thru_a: assert property (
    (!kpd_lost_q && !cmd_lost_q) |=> O_OPER_FREQ == $past(I_SPEED_CMD))
    else $error("speed command not passed through");
  kpd_warn_a: assert property (
    (warn_d && term_fn_q[7:0] == cmdloss_pkg::FN_LOST_KPD) |=> O_TERM[0])
    else $error("keypad warning terminal not set");
  kpd_block_a: assert property (
    (kpd_lost_q && kpd_act_q == cmdloss_pkg::KPD_FREE)
      |=> O_OUT_BLOCK && O_OPER_FREQ == '0)
    else $error("keypad loss did not block output");
  decel_ramp_a: assert property (
    (O_DECEL_STOP && $past(O_DECEL_STOP))
      |-> O_OPER_FREQ <= $past(O_OPER_FREQ))
    else $error("frequency rose while decelerating");
  cmd_dec_a: assert property (
    (cmd_lost_q && cmd_act_q == cmdloss_pkg::CL_DEC && !block_d)
      |=> O_DECEL_STOP)
    else $error("decelerate mode not entered");
  cmd_block_a: assert property (
    (cmd_lost_q && cmd_act_q == cmdloss_pkg::CL_FREE) |=> O_OUT_BLOCK)
    else $error("command loss did not block output");
  hold_in_a: assert property (
    (cmd_lost_q && cmd_act_q == cmdloss_pkg::CL_HOLD_IN && !block_d &&
     !dec_d) |=> O_OPER_FREQ == $past(avg_in.avg))
    else $error("hold input average not used");
  hold_out_a: assert property (
    (cmd_lost_q && cmd_act_q == cmdloss_pkg::CL_HOLD_OUT && !block_d &&
     !dec_d) |=> O_OPER_FREQ == $past(avg_out.avg))
    else $error("hold output average not used");
  preset_run_a: assert property (
    (cmd_lost_q && cmd_act_q == cmdloss_pkg::CL_PRESET && !block_d &&
     !dec_d) |=> O_OPER_FREQ >= $past(f_start) &&
                 O_OPER_FREQ <= $past(f_max))
    else $error("preset frequency out of range");
  decide_time_a: assert property (
    $rose(cmd_lost_q) |-> $past(loss_cnt_q) >= $past(decide_q))
    else $error("loss declared before decision time");
  comm_run_a: assert property (
    (cmd_src == cmdloss_pkg::SRC_COMM && I_COMM_RUN_LOST &&
     decide_q == '0) |=> cmd_lost_q)
    else $error("comm run loss not detected");
  lost_term_a: assert property (
    (cmd_lost_q && term_fn_q[15:8] == cmdloss_pkg::FN_LOST_CMD)
      |=> O_TERM[1])
    else $error("lost command terminal not set");

  kpd_loss_c:  cover property ($rose(kpd_lost_q));
  cmd_loss_c:  cover property ($rose(cmd_lost_q));
  decel_end_c: cover property (O_DECEL_STOP && O_OPER_FREQ == '0);
  recover_c:   cover property ($fell(cmd_lost_q));
endmodule

// ==== core/cmdloss_pkg.sv ====
// constants for the command loss protection block
package cmdloss_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_TIME_MS  = 100;
  localparam int unsigned TICK_CYCLES   =
    TICK_TIME_MS * 1000 * 1000 / CLK_PERIOD_NS;
  localparam int unsigned AVG_WINDOW_S  = 10;
  localparam int unsigned AVG_DEPTH     =
    AVG_WINDOW_S * 1000 / TICK_TIME_MS;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned FREQ_W = 16;
  localparam int unsigned AI_W   = 12;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned TERM_N = 3;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_SRC_CFG  = 8'h00;
  localparam logic [7:0] OFS_KPD_ACT  = 8'h04;
  localparam logic [7:0] OFS_CMD_ACT  = 8'h08;
  localparam logic [7:0] OFS_DEC_TIME = 8'h0C;
  localparam logic [7:0] OFS_DECIDE   = 8'h10;
  localparam logic [7:0] OFS_PRESET   = 8'h14;
  localparam logic [7:0] OFS_AI_LEVEL = 8'h18;
  localparam logic [7:0] OFS_AI_X1    = 8'h1C;
  localparam logic [7:0] OFS_FLIMIT   = 8'h20;
  localparam logic [7:0] OFS_TERM_FN  = 8'h24;
  localparam logic [7:0] OFS_STATE    = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h34;
  localparam logic [7:0] OFS_FREQ     = 8'h38;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned SRC_CMD_LSB  = 0;
  localparam int unsigned SRC_SPD_LSB  = 2;
  localparam int unsigned SRC_MKEY_LSB = 4;
  localparam int unsigned FL_MAX_LSB   = 16;
  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] SRC_COMM   = 2'h2;
  localparam logic [2:0] MKEY_JOG   = 3'h0;
  localparam logic [1:0] KPD_NONE   = 2'h0;
  localparam logic [1:0] KPD_WARN   = 2'h1;
  localparam logic [1:0] KPD_FREE   = 2'h2;
  localparam logic [1:0] KPD_DEC    = 2'h3;
  localparam logic [2:0] CL_NONE    = 3'h0;
  localparam logic [2:0] CL_FREE    = 3'h1;
  localparam logic [2:0] CL_DEC     = 3'h2;
  localparam logic [2:0] CL_HOLD_IN = 3'h3;
  localparam logic [2:0] CL_HOLD_OUT = 3'h4;
  localparam logic [2:0] CL_PRESET  = 3'h5;
  localparam logic       AI_HALF_X1 = 1'b0;
  localparam logic [7:0] FN_LOST_KPD = 8'h1D;
  localparam logic [7:0] FN_LOST_CMD = 8'h0D;
  localparam int unsigned IRQ_N      = 3;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [6:0]  RST_SRC_CFG  = 7'h00;
  localparam logic [1:0]  RST_KPD_ACT  = 2'h2;
  localparam logic [2:0]  RST_CMD_ACT  = 3'h1;
  localparam logic [15:0] RST_DEC_TIME = 16'h0032;
  localparam logic [15:0] RST_DECIDE   = 16'h000A;
  localparam logic [15:0] RST_PRESET   = 16'h0000;
  localparam logic        RST_AI_LEVEL = 1'b0;
  localparam logic [11:0] RST_AI_X1    = 12'h0800;
  localparam logic [31:0] RST_FLIMIT   = 32'h1770_0032;
  localparam logic [23:0] RST_TERM_FN  = 24'h00_0000;
endpackage

// ==== core/avg_if.sv ====
// carrier between the protection core and a window averager
`timescale 1ns/100ps
interface avg_if #(parameter int unsigned W = 16);
  logic         tick;
  logic         freeze;
  logic [W-1:0] sample;
  logic [W-1:0] avg;
  modport src (output tick, freeze, sample, input avg);
  modport avg_m (input tick, freeze, sample, output avg);
endinterface

// ==== core/window_avg.sv ====
// running average over the last DEPTH tick samples
`timescale 1ns/100ps
module window_avg #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 100
) (
  // clock and reset
  input  wire logic I_CORE_CLK,
  input  wire logic I_ARST_N,
  // sample stream and result
  avg_if.avg_m      a
);
  localparam int unsigned SW = W + $clog2(DEPTH + 1);
  localparam int unsigned IW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [IW-1:0] idx_q;
  logic [SW-1:0] sum_q;

  // ---------------------------------------------------------------
  // ring of samples, frozen once loss is declared
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      idx_q <= '0;
      sum_q <= '0;
    end else if (a.tick && !a.freeze) begin
      mem_q[idx_q] <= a.sample;
      sum_q        <= sum_q + SW'(a.sample) - SW'(mem_q[idx_q]);
      idx_q        <= (idx_q == IW'(DEPTH - 1)) ? '0 : idx_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // result
  // ---------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      a.avg <= '0;
    end else begin
      a.avg <= W'(sum_q / SW'(DEPTH));
    end
  end
endmodule

// ==== sim/cmd_src_model.sv ====
// far side model: keypad link, comm option and speed source
`timescale 1ns/100ps
module cmd_src_model (
  input  wire logic        i_kpd_cut,
  input  wire logic        i_comm_cut,
  input  wire logic [15:0] i_speed,
  output logic             o_keypad_ok,
  output logic             o_comm_lost,
  output logic      [15:0] o_speed
);
  // cable cut drops the keypad, comm timeout raises the lost flag
  assign o_keypad_ok = !i_kpd_cut;
  assign o_comm_lost = i_comm_cut;
  assign o_speed     = i_speed;
endmodule

// ==== sim/command_loss_protection_tb_top.sv ====
// self-checking bench for the command loss protection core
`timescale 1ns/100ps
module command_loss_protection_tb_top;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, kcut = 0, ccut = 0;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [15:0] spd = 16'h1234, freq, m_spd;
  logic        kok, clost, blk, dec, irq;
  logic        jog = 0, run = 0;
  logic [11:0] ai = 12'hFFF;
  logic [2:0]  term;
  int          num_errors = 0, compares = 0;
  initial forever #10 clk = ~clk;
  cmd_src_model src (.i_kpd_cut(kcut), .i_comm_cut(ccut), .i_speed(spd),
    .o_keypad_ok(kok), .o_comm_lost(clost), .o_speed(m_spd));
  cmd_loss_prot #(.TICK_CYCLES(10), .AVG_DEPTH(4)) dut (
    .I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SPEED_CMD(m_spd),
    .I_ANALOG_IN(ai), .I_KEYPAD_OK(kok), .I_JOG_ACTIVE(jog),
    .I_COMM_SPD_LOST(clost), .I_COMM_RUN_LOST(run), .O_OPER_FREQ(freq),
    .O_OUT_BLOCK(blk), .O_DECEL_STOP(dec), .O_TERM(term), .O_IRQ(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, exp);
  endtask
  task lose(input logic k, input logic c);
    @(posedge clk);
    kcut <= k;
    ccut <= c;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task stop_test;
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    rd_chk(cmdloss_pkg::OFS_KPD_ACT, 2);
    rd_chk(cmdloss_pkg::OFS_CMD_ACT, 1);
    rd_chk(cmdloss_pkg::OFS_DECIDE, 8'h0A);
    rd_chk(8'hFC, 0);
    wr_reg(cmdloss_pkg::OFS_IRQ_EN, 1);
    lose(1, 0);
    chk(blk, 1);
    chk(irq, 1);
    wr_reg(cmdloss_pkg::OFS_IRQ_EN, 0);
    lose(0, 0);
    chk(irq, 0);
    rd_chk(cmdloss_pkg::OFS_IRQ_STAT, 1);
    wr_reg(cmdloss_pkg::OFS_IRQ_CLR, 7);
    rd_chk(cmdloss_pkg::OFS_IRQ_STAT, 0);
    wr_reg(cmdloss_pkg::OFS_KPD_ACT, 0);
    lose(1, 0);
    chk(freq, spd);
    chk(blk, 0);
    wr_reg(cmdloss_pkg::OFS_KPD_ACT, 1);
    wr_reg(cmdloss_pkg::OFS_TERM_FN, 8'h1D);
    lose(1, 0);
    chk(term, 1);
    chk(blk, 0);
    wr_reg(cmdloss_pkg::OFS_KPD_ACT, 2);
    wr_reg(cmdloss_pkg::OFS_SRC_CFG, 5);
    lose(1, 0);
    chk(blk, 0);
    wr_reg(cmdloss_pkg::OFS_SRC_CFG, 8);
    wr_reg(cmdloss_pkg::OFS_DECIDE, 0);
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 5);
    wr_reg(cmdloss_pkg::OFS_PRESET, 16'h0100);
    wr_reg(cmdloss_pkg::OFS_TERM_FN, 16'h0D00);
    lose(0, 1);
    chk(freq, 16'h0100);
    chk(term, 2);
    wr_reg(cmdloss_pkg::OFS_PRESET, 0);
    lose(0, 1);
    chk(freq, cmdloss_pkg::RST_FLIMIT[15:0]);
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 1);
    lose(0, 1);
    chk(blk, 1);
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 2);
    lose(0, 1);
    chk(dec, 1);
    lose(0, 0);
    chk(term, 0);
    wr_reg(cmdloss_pkg::OFS_DECIDE, 3);
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 1);
    lose(0, 1);
    chk(blk, 0);
    repeat (40) @(posedge clk);
    #1 chk(blk, 1);
    lose(0, 0);
    wr_reg(cmdloss_pkg::OFS_DECIDE, 0);
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 4);
    lose(1, 0);
    repeat (60) @(posedge clk);
    lose(0, 1);
    chk(freq, 0);
    chk(blk, 0);
    @(posedge clk);
    spd <= 16'h0100;
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 3);
    lose(0, 1);
    chk(freq, 16'h1234);
    lose(0, 0);
    wr_reg(cmdloss_pkg::OFS_KPD_ACT, 3);
    wr_reg(cmdloss_pkg::OFS_DEC_TIME, 1);
    lose(1, 0);
    chk(dec, 1);
    chk(freq > 16'h00C8, 1);
    repeat (300) @(posedge clk);
    #1 chk(freq, 0);
    lose(0, 0);
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 2);
    lose(0, 1);
    chk(freq > 16'h00C8, 1);
    repeat (300) @(posedge clk);
    #1 chk(freq, 0);
    wr_reg(cmdloss_pkg::OFS_CMD_ACT, 1);
    wr_reg(cmdloss_pkg::OFS_KPD_ACT, 2);
    wr_reg(cmdloss_pkg::OFS_SRC_CFG, 5);
    @(posedge clk);
    ai <= 12'h400;
    lose(0, 0);
    chk(blk, 1);
    @(posedge clk);
    ai <= 12'h401;
    lose(0, 0);
    chk(blk, 0);
    @(posedge clk);
    jog <= 1;
    lose(1, 0);
    chk(blk, 1);
    @(posedge clk);
    jog <= 0;
    lose(1, 0);
    chk(blk, 0);
    wr_reg(cmdloss_pkg::OFS_SRC_CFG, 6);
    @(posedge clk);
    run <= 1;
    lose(0, 0);
    chk(blk, 1);
    stop_test;
  end
endmodule
